// >>> rtl/uart_iifc_pkg.sv
package uart_iifc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int IER_W = 4;
    localparam int EVT_W = 3;
    localparam logic [ADDR_W-1:0] OFF_IER = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_IIFC = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_MASK = 4'h9;
    localparam int BIT_DMA = 3;
    localparam int BIT_TXR = 2;
    localparam int BIT_RXR = 1;
    localparam int BIT_QE = 0;
    localparam int IER_RX = 0;
    localparam int IER_TX = 1;
    localparam int IER_LS = 2;
    localparam int IER_MS = 3;
    localparam int EV_TXR = 0;
    localparam int EV_RXR = 1;
    localparam int EV_QE = 2;
    localparam logic RST_QE = 1'h1;
    localparam logic RST_DMA = 1'h0;
    localparam logic [IER_W-1:0] RST_IER = 4'h0;
    localparam logic [EVT_W-1:0] RST_EVT = 3'h0;
    localparam logic [3:0] CODE_NONE = 4'h1;
    localparam logic [3:0] CODE_THRE = 4'h2;
    localparam logic [3:0] CODE_RDA = 4'h4;
    localparam logic [3:0] CODE_RLS = 4'h6;
    localparam logic [3:0] CODE_BUSY = 4'h7;
    localparam logic [3:0] CODE_CTO = 4'hC;
    localparam logic [3:0] CODE_MODEM = 4'h0;
endpackage : uart_iifc_pkg

// >>> rtl/evt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface evt_if;
    import uart_iifc_pkg::*;
    logic [EVT_W-1:0] event_set;
    logic [DATA_W-1:0] wdata;
    logic wr_status;
    logic wr_mask;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    modport src (output event_set, wdata, wr_status, wr_mask, input status, mask);
    modport sink (input event_set, wdata, wr_status, wr_mask, output status, mask);
endinterface : evt_if
`default_nettype wire

// >>> rtl/event_flags.sv
`timescale 1ns/1ps
`default_nettype none
module event_flags
(
    input wire logic ref_clk,
    input wire logic rst_n,
    evt_if.sink ev,
    output logic irq
);
    import uart_iifc_pkg::*;
    logic [EVT_W-1:0] next_status;
    logic [EVT_W-1:0] next_mask;
    logic next_irq;

    // Set wins over a write-one clear in the same cycle
    always_comb
    begin
        next_status = ev.status;
        next_mask = ev.mask;
        if (ev.wr_status)
            next_status = ev.status & ~ev.wdata[EVT_W-1:0];
        next_status = next_status | ev.event_set;
        if (ev.wr_mask)
            next_mask = ev.wdata[EVT_W-1:0];
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ev.status <= RST_EVT;
            ev.mask <= RST_EVT;
            irq <= 1'b0;
        end
        else
        begin
            ev.status <= next_status;
            ev.mask <= next_mask;
            irq <= next_irq;
        end
    end

    a_set_beats_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ev.event_set[0] |=> ev.status[0])
        else $error("event lost against clear");

    a_irq_follows_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
        irq == |(ev.status & ev.mask))
        else $error("irq does not follow flags");
endmodule : event_flags
`default_nettype wire

// >>> rtl/int_priority.sv
`timescale 1ns/1ps
`default_nettype none
module int_priority
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic line_status_pend,
    input wire logic rx_data_pend,
    input wire logic char_timeout_pend,
    input wire logic thr_empty_pend,
    input wire logic modem_status_pend,
    input wire logic busy_detect_pend,
    input wire logic [uart_iifc_pkg::IER_W-1:0] ier,
    input wire logic queue_enable,
    output logic [3:0] code
);
    import uart_iifc_pkg::*;
    logic [3:0] next_code;

    always_comb
    begin
        next_code = CODE_NONE;
        if (line_status_pend && ier[IER_LS])
            next_code = CODE_RLS;
        else if (rx_data_pend && ier[IER_RX])
            next_code = CODE_RDA;
        else if (char_timeout_pend && ier[IER_RX] && queue_enable)
            next_code = CODE_CTO;
        else if (thr_empty_pend && ier[IER_TX])
            next_code = CODE_THRE;
        else if (modem_status_pend && ier[IER_MS])
            next_code = CODE_MODEM;
        else if (busy_detect_pend)
            next_code = CODE_BUSY;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            code <= CODE_NONE;
        else
            code <= next_code;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_line_status_first: assert property (
        line_status_pend && ier[IER_LS] |=> code == CODE_RLS)
        else $error("line status not first");
    a_timeout_gated: assert property (
        code == CODE_CTO |-> $past(queue_enable) && $past(ier[IER_RX]))
        else $error("timeout raised while gated");
    a_none_code: assert property (
        !line_status_pend && !rx_data_pend && !char_timeout_pend && !thr_empty_pend
        && !modem_status_pend && !busy_detect_pend |=> code == CODE_NONE)
        else $error("idle code wrong");
endmodule : int_priority
`default_nettype wire

// >>> rtl/uart_int_ident_fifo_ctrl.sv
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module uart_int_ident_fifo_ctrl
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [uart_iifc_pkg::ADDR_W-1:0] addr,
    input wire logic [uart_iifc_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [uart_iifc_pkg::DATA_W-1:0] rdata,
    input wire logic line_status_pend,
    input wire logic rx_data_pend,
    input wire logic char_timeout_pend,
    input wire logic thr_empty_pend,
    input wire logic modem_status_pend,
    input wire logic busy_detect_pend,
    output logic [3:0] pending_int_code,
    output logic queue_enable,
    output logic dma_signal_mode,
    output logic tx_queue_reset,
    output logic rx_queue_reset,
    output logic irq
);
    import uart_iifc_pkg::*;

    logic [IER_W-1:0] ier;
    logic [IER_W-1:0] next_ier;
    logic next_queue_enable;
    logic next_dma_signal_mode;
    logic next_tx_queue_reset;
    logic next_rx_queue_reset;
    logic [DATA_W-1:0] next_rdata;
    logic wr_iifc;
    logic wr_ier;
    logic qe_change;
    evt_if ev ();

    assign wr_iifc = wr_en && (addr == OFF_IIFC);
    assign wr_ier = wr_en && (addr == OFF_IER);
    assign qe_change = wr_iifc && (wdata[BIT_QE] != queue_enable);

    // Write-side controls
    always_comb
    begin
        next_queue_enable = queue_enable;
        next_dma_signal_mode = dma_signal_mode;
        next_tx_queue_reset = 1'b0;
        next_rx_queue_reset = 1'b0;
        next_ier = ier;
        if (wr_iifc)
        begin
            next_queue_enable = wdata[BIT_QE];
            next_dma_signal_mode = wdata[BIT_DMA];
            // Pulse lasts one cycle, so software never has to clear it
            next_tx_queue_reset = wdata[BIT_TXR] || qe_change;
            next_rx_queue_reset = wdata[BIT_RXR] || qe_change;
        end
        if (wr_ier)
            next_ier = wdata[IER_W-1:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            queue_enable <= RST_QE;
            dma_signal_mode <= RST_DMA;
            tx_queue_reset <= 1'b0;
            rx_queue_reset <= 1'b0;
            ier <= RST_IER;
        end
        else
        begin
            queue_enable <= next_queue_enable;
            dma_signal_mode <= next_dma_signal_mode;
            tx_queue_reset <= next_tx_queue_reset;
            rx_queue_reset <= next_rx_queue_reset;
            ier <= next_ier;
        end
    end

    // Read side; at OFF_IIFC the low nibble is only ever the pending code
    always_comb
    begin
        next_rdata = '0;
        if (rd_en)
        begin
            unique case (addr)
                OFF_IER: next_rdata = {{(DATA_W-IER_W){1'b0}}, ier};
                OFF_IIFC: next_rdata = {{2{queue_enable}}, 2'b00, pending_int_code};
                OFF_STATUS: next_rdata = {{(DATA_W-EVT_W){1'b0}}, ev.status};
                OFF_MASK: next_rdata = {{(DATA_W-EVT_W){1'b0}}, ev.mask};
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            rdata <= '0;
        else
            rdata <= next_rdata;
    end

    // Events use the same next values as the pulses, so status and outputs change on one edge
    assign ev.event_set = {qe_change, next_rx_queue_reset, next_tx_queue_reset};
    assign ev.wdata = wdata;
    assign ev.wr_status = wr_en && (addr == OFF_STATUS);
    assign ev.wr_mask = wr_en && (addr == OFF_MASK);

    event_flags u_flags
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ev(ev),
        .irq(irq)
    );

    int_priority u_prio
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .line_status_pend(line_status_pend),
        .rx_data_pend(rx_data_pend),
        .char_timeout_pend(char_timeout_pend),
        .thr_empty_pend(thr_empty_pend),
        .modem_status_pend(modem_status_pend),
        .busy_detect_pend(busy_detect_pend),
        .ier(ier),
        .queue_enable(queue_enable),
        .code(pending_int_code)
    );

    sequence s_txr_write;
        wr_iifc && wdata[BIT_TXR];
    endsequence

    sequence s_rxr_write;
        wr_iifc && wdata[BIT_RXR];
    endsequence

    sequence s_qe_flip;
        wr_iifc && (wdata[BIT_QE] != queue_enable);
    endsequence

    sequence s_quiet_write;
        wr_iifc && !wdata[BIT_TXR] && !wdata[BIT_RXR] && (wdata[BIT_QE] == queue_enable);
    endsequence

    a_tx_reset_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_txr_write |=> tx_queue_reset ##1 (!tx_queue_reset || $past(wr_iifc)))
        else $error("tx reset pulse wrong");

    a_rx_reset_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_rxr_write |=> rx_queue_reset ##1 (!rx_queue_reset || $past(wr_iifc)))
        else $error("rx reset pulse wrong");

    a_reset_has_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_queue_reset || rx_queue_reset |-> $past(wr_iifc))
        else $error("queue reset without write");

    a_enable_stored: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_iifc |=> queue_enable == $past(wdata[BIT_QE]))
        else $error("queue enable not stored");

    a_enable_flip_resets: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_qe_flip |=> tx_queue_reset && rx_queue_reset)
        else $error("enable change did not reset queues");

    a_dma_mode_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_iifc |=> dma_signal_mode == $past(wdata[BIT_DMA]))
        else $error("dma mode not stored");

    a_reset_values: assert property (@(posedge ref_clk) disable iff (1'b0)
        !rst_n |=> queue_enable && !dma_signal_mode && !tx_queue_reset && !rx_queue_reset)
        else $error("reset values wrong");

    a_read_code_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_en && addr == OFF_IIFC |=> rdata[3:0] == $past(pending_int_code))
        else $error("read returned written value");

    a_read_upper: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_en && addr == OFF_IIFC |=> rdata[7:4] == {{2{$past(queue_enable)}}, 2'b00})
        else $error("read upper bits wrong");

    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !rd_en |=> rdata == '0)
        else $error("read data not idle");

    a_same_enable_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_quiet_write |=> !tx_queue_reset && !rx_queue_reset)
        else $error("queue reset without cause");
endmodule : uart_int_ident_fifo_ctrl
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import uart_iifc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [5:0] pend = 6'h00;
    logic [DATA_W-1:0] rdata;
    logic [3:0] code;
    logic qe;
    logic dma;
    logic txr;
    logic rxr;
    logic irq;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;

    uart_int_ident_fifo_ctrl u_uart_int_ident_fifo_ctrl
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .addr(addr),
        .wdata(wdata),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rdata(rdata),
        .line_status_pend(pend[0]),
        .rx_data_pend(pend[1]),
        .char_timeout_pend(pend[2]),
        .thr_empty_pend(pend[3]),
        .modem_status_pend(pend[4]),
        .busy_detect_pend(pend[5]),
        .pending_int_code(code),
        .queue_enable(qe),
        .dma_signal_mode(dma),
        .tx_queue_reset(txr),
        .rx_queue_reset(rxr),
        .irq(irq)
    );

    always #20 ref_clk = ~ref_clk;

    // Tests need about 130 cycles, so a hang is cut at 3000 cycles, well before the run grows long
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic chk_bit(input string n, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk_byte

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic chk_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        chk_byte("rdata", e, rdata);
    endtask : chk_reg

    // Order: queue_enable, dma_signal_mode, tx_queue_reset, rx_queue_reset
    task automatic chk_ctl(input logic [3:0] e);
        chk_byte("ctl", {4'h0, e}, {4'h0, qe, dma, txr, rxr});
    endtask : chk_ctl

    task automatic pend_chk(input logic [5:0] v, input logic [3:0] e);
        @(posedge ref_clk);
        pend <= v;
        tick(1);
        chk_byte("code", {4'h0, e}, {4'h0, code});
    endtask : pend_chk

    task automatic t_reset();
        tick(1);
        chk_ctl(4'h8);
        chk_bit("irq", 1'b0, irq);
        chk_byte("code", 8'h01, {4'h0, code});
        chk_reg(OFF_IIFC, 8'hC1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_resets();
        wr(OFF_MASK, 8'h07);
        chk_bit("irq", 1'b0, irq);
        wr(OFF_IIFC, 8'h05);
        chk_ctl(4'hA);
        chk_bit("irq", 1'b1, irq);
        tick(1);
        chk_ctl(4'h8);
        chk_reg(OFF_STATUS, 8'h01);
        wr(OFF_MASK, 8'h06);
        chk_bit("irq", 1'b0, irq);
        wr(OFF_IIFC, 8'h03);
        chk_ctl(4'h9);
        chk_bit("irq", 1'b1, irq);
        tick(1);
        chk_ctl(4'h8);
        wr(OFF_STATUS, 8'h03);
        chk_bit("irq", 1'b0, irq);
        chk_reg(OFF_STATUS, 8'h00);
        chk_reg(OFF_MASK, 8'h06);
        wr(4'hF, 8'hFF);
        chk_reg(4'hF, 8'h00);
        chk_reg(OFF_IIFC, 8'hC1);
        $display("test resets done");
    endtask : t_resets

    task automatic t_dma();
        wr(OFF_IIFC, 8'h09);
        chk_ctl(4'hC);
        chk_reg(OFF_IIFC, 8'hC1);
        wr(OFF_IIFC, 8'h01);
        chk_ctl(4'h8);
        $display("test dma done");
    endtask : t_dma

    task automatic t_enable();
        wr(OFF_IIFC, 8'h00);
        chk_ctl(4'h3);
        tick(1);
        chk_ctl(4'h0);
        chk_reg(OFF_IIFC, 8'h01);
        wr(OFF_IIFC, 8'h00);
        chk_ctl(4'h0);
        wr(OFF_IIFC, 8'h01);
        chk_ctl(4'hB);
        tick(1);
        chk_ctl(4'h8);
        $display("test enable done");
    endtask : t_enable

    task automatic t_prio();
        logic [5:0] pv [12] = '{6'h00, 6'h20, 6'h10, 6'h30, 6'h08, 6'h38,
                                6'h04, 6'h0C, 6'h02, 6'h06, 6'h01, 6'h3F};
        logic [3:0] cv [12] = '{4'h1, 4'h7, 4'h0, 4'h0, 4'h2, 4'h2,
                                4'hC, 4'hC, 4'h4, 4'h4, 4'h6, 4'h6};
        wr(OFF_IER, 8'h0F);
        chk_reg(OFF_IER, 8'h0F);
        for (int i = 0; i < 12; i++)
            pend_chk(pv[i], cv[i]);
        chk_reg(OFF_IIFC, 8'hC6);
        wr(OFF_IER, 8'h00);
        pend_chk(6'h1F, 4'h1);
        pend_chk(6'h3F, 4'h7);
        wr(OFF_IER, 8'h01);
        wr(OFF_IIFC, 8'h00);
        pend_chk(6'h04, 4'h1);
        pend_chk(6'h06, 4'h4);
        wr(OFF_IIFC, 8'h01);
        pend_chk(6'h04, 4'hC);
        $display("test priority done");
    endtask : t_prio

    task automatic t_midreset();
        wr(OFF_IER, 8'h0F);
        wr(OFF_MASK, 8'h07);
        wr(OFF_IIFC, 8'h08);
        chk_ctl(4'h7);
        chk_bit("irq", 1'b1, irq);
        @(posedge ref_clk);
        pend <= 6'h00;
        rst_n <= 1'b0;
        tick(3);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        tick(1);
        chk_ctl(4'h8);
        chk_bit("irq", 1'b0, irq);
        chk_byte("code", 8'h01, {4'h0, code});
        chk_reg(OFF_IER, 8'h00);
        chk_reg(OFF_STATUS, 8'h00);
        chk_reg(OFF_MASK, 8'h00);
        chk_reg(OFF_IIFC, 8'hC1);
        tick(1);
        chk_byte("rdata", 8'h00, rdata);
        $display("test mid-run reset done");
    endtask : t_midreset

    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_resets();
        t_dma();
        t_enable();
        t_prio();
        t_midreset();
        test_done();
    end
endmodule : tb_top
`default_nettype wire
